// ===== hdl/elp_line_scan.sv
// line scan input of the 640-column el matrix panel
`timescale 1ns/100ps
module elp_line_scan (
    input  wire logic                              core_clk,
    input  wire logic                              resetn,
    input  wire logic                              pixel_shift_clock,
    input  wire logic [elp_pkg::BUS_WIDTH-1:0]     pixel_data_bus,
    input  wire logic                              line_latch_pulse,
    input  wire logic                              frame_start,
    input  wire logic                              display_enable,
    input  wire logic                              line_select,
    output logic [elp_pkg::DOTS_PER_ROW-1:0]       col_drive,
    output logic [elp_pkg::ROW_IDX_W-1:0]          row_drive,
    output logic                                   row_pair,
    output logic                                   panel_on,
    output logic                                   line_strobe,
    input  wire logic                              line_ready,
    output logic                                   overrun
);
    logic [1:0]                           clk_s_q;
    logic [1:0]                           lat_s_q;
    logic [1:0]                           frm_s_q;
    logic [1:0]                           en_s_q;
    logic [1:0]                           sel_s_q;
    logic [elp_pkg::BUS_WIDTH-1:0]        dat_s1_q;
    logic [elp_pkg::BUS_WIDTH-1:0]        dat_s2_q;
    logic                                 clk_prev_q;
    logic                                 lat_prev_q;
    logic                                 shift_fall;
    logic                                 latch_fall;
    logic [elp_pkg::DOTS_PER_ROW-1:0]     shreg_q;
    logic [elp_pkg::BEAT_IDX_W-1:0]       beat_q;
    logic [elp_pkg::ROW_IDX_W-1:0]        row_q;
    logic                                 first_q;
    logic                                 dual_q;
    logic                                 buf_in_ready;
    logic                                 buf_out_valid;
    logic                                 buf_pop;
    elp_pkg::elp_line_t                   buf_in;
    elp_pkg::elp_line_t                   buf_out;
    logic [elp_pkg::ROW_IDX_W-1:0]        row_last;

    // two-stage synchronisers; first stages read only by second
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clk_s_q  <= 2'h0;
            lat_s_q  <= 2'h0;
            frm_s_q  <= 2'h0;
            en_s_q   <= 2'h0;
            sel_s_q  <= 2'h0;
        end else begin
            clk_s_q  <= {clk_s_q[0], pixel_shift_clock};
            lat_s_q  <= {lat_s_q[0], line_latch_pulse};
            frm_s_q  <= {frm_s_q[0], frame_start};
            en_s_q   <= {en_s_q[0], display_enable};
            sel_s_q  <= {sel_s_q[0], line_select};
        end
    end

    // bus only sampled while it stands still, so no gray code needed
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dat_s1_q <= 4'h0;
            dat_s2_q <= 4'h0;
        end else begin
            dat_s1_q <= pixel_data_bus;
            dat_s2_q <= dat_s1_q;
        end
    end

    // clock and data pass the same two stages so setup time is kept after sync
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_s_q[1];
        end
    end

    // latch edge detector; idle low like its reset value, no false edge
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lat_prev_q <= 1'b0;
        end else begin
            lat_prev_q <= lat_s_q[1];
        end
    end

    assign shift_fall = clk_prev_q && !clk_s_q[1];
    assign latch_fall = lat_prev_q && !lat_s_q[1];

    // first beat ends up at the left column
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            shreg_q <= '0;
            beat_q  <= elp_pkg::BEAT_RESET;
        end else if (shift_fall) begin
            shreg_q <= {shreg_q[elp_pkg::DOTS_PER_ROW-elp_pkg::BUS_WIDTH-1:0], dat_s2_q};
            beat_q  <= (beat_q == elp_pkg::BEAT_LAST) ? elp_pkg::BEAT_RESET : beat_q + 8'h01;
        end else if (latch_fall) begin
            beat_q  <= elp_pkg::BEAT_RESET;
        end
    end

    // mode only follows the pin while the panel is off
    // gate is one stage behind the sync so a select held through reset is caught
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dual_q <= 1'b0;
        end else if (!panel_on) begin
            dual_q <= sel_s_q[1];
        end
    end

    assign row_last = dual_q ? elp_pkg::ROW_LAST_DUAL : elp_pkg::ROW_LAST_NORM;

    // frame start sampled at the latch edge restarts the scan
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            row_q <= elp_pkg::ROW_RESET;
        end else if (latch_fall) begin
            if (frm_s_q[1]) begin
                row_q <= elp_pkg::ROW_RESET;
            end else if (first_q || row_q == row_last) begin
                row_q <= elp_pkg::ROW_RESET;
            end else begin
                row_q <= row_q + 7'h01;
            end
        end
    end

    // nothing latched since reset: the next line lands on the top row
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            first_q <= 1'b1;
        end else if (latch_fall) begin
            first_q <= 1'b0;
        end
    end

    // row index used for this latch; frame start forces the top line
    always_comb begin
        buf_in.dots = shreg_q;
        buf_in.dual = dual_q;
        if (frm_s_q[1] || first_q || row_q == row_last) begin
            buf_in.row = elp_pkg::ROW_RESET;
        end else begin
            buf_in.row = row_q + 7'h01;
        end
    end

    // a line latched while both entries are full is dropped and flagged
    elp_line_buf u_buf (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (latch_fall),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (buf_out_valid),
        .out_ready (line_ready),
        .out_data  (buf_out)
    );


    assign buf_pop = buf_out_valid && line_ready;

    // one-cycle pulses: line delivered, line dropped
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            line_strobe <= 1'b0;
            overrun     <= 1'b0;
        end else begin
            line_strobe <= buf_pop;
            overrun     <= latch_fall && !buf_in_ready;
        end
    end

    // column latches hold until the next delivered line
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            col_drive <= '0;
        end else if (buf_pop) begin
            col_drive <= buf_out.dots;
        end
    end

    // row select and pair flag travel with the columns
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            row_drive <= elp_pkg::ROW_RESET;
            row_pair  <= 1'b0;
        end else if (buf_pop) begin
            row_drive <= buf_out.row;
            row_pair  <= buf_out.dual;
        end
    end

    // columns keep updating while dark; the consumer gates on panel_on

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            panel_on <= 1'b0;
        end else begin
            panel_on <= en_s_q[1];
        end
    end
endmodule : elp_line_scan

// ===== hdl/elp_pkg.sv
// shared constants and carriers for the panel line scan input
package elp_pkg;
    localparam int          DOTS_PER_ROW   = 640;
    localparam int          BUS_WIDTH      = 4;
    localparam int          BEATS_PER_ROW  = DOTS_PER_ROW / BUS_WIDTH;
    localparam int          ROWS_NORMAL    = 128;
    localparam int          ROWS_DUAL      = 64;
    localparam int          ROW_IDX_W      = 7;
    localparam int          BEAT_IDX_W     = 8;
    localparam int          BUF_DEPTH      = 2;
    localparam logic [6:0]  ROW_LAST_NORM  = 7'h7f;
    localparam logic [6:0]  ROW_LAST_DUAL  = 7'h3f;
    localparam logic [6:0]  ROW_RESET      = 7'h00;
    localparam logic [7:0]  BEAT_RESET     = 8'h00;
    localparam logic [7:0]  BEAT_LAST      = 8'h9f;

    // one latched line travelling to the panel drivers
    typedef struct packed {
        logic [DOTS_PER_ROW-1:0] dots;
        logic [ROW_IDX_W-1:0]    row;
        logic                    dual;
    } elp_line_t;
endpackage : elp_pkg

// ===== hdl/elp_line_buf.sv
// two-entry valid/ready buffer for latched lines
`timescale 1ns/100ps
module elp_line_buf (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire elp_pkg::elp_line_t in_data,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output elp_pkg::elp_line_t     out_data
);
    elp_pkg::elp_line_t mem_q [elp_pkg::BUF_DEPTH];
    logic               wr_q;
    logic               rd_q;
    logic [1:0]         cnt_q;
    logic               push;
    logic               pop;

    assign push      = in_valid && (cnt_q != 2'(elp_pkg::BUF_DEPTH));
    assign pop       = out_valid && out_ready;
    assign in_ready  = (cnt_q != 2'(elp_pkg::BUF_DEPTH));
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

    // storage needs no reset; valid gates it
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : elp_line_buf

// ===== verification/elp_line_scan_props.sv
// checker for the panel line scan input
`timescale 1ns/100ps
module elp_line_scan_props (
    input wire logic         core_clk,
    input wire logic         resetn,
    input wire logic         line_latch_pulse,
    input wire logic         frame_start,
    input wire logic         display_enable,
    input wire logic [639:0] col_drive,
    input wire logic [6:0]   row_drive,
    input wire logic         row_pair,
    input wire logic         panel_on,
    input wire logic         line_strobe,
    input wire logic         line_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_fall;
        $fell(line_latch_pulse) && line_ready;
    endsequence
    sequence s_row0;
        line_strobe && row_drive == 7'h00;
    endsequence
    chk_cols_hold: assert property (!line_strobe |-> $stable(col_drive)) else $error("cols moved");
    chk_row_hold: assert property (!line_strobe |-> $stable(row_drive)) else $error("row moved");
    chk_pair_range: assert property (row_pair |-> row_drive < 7'h40) else $error("pair row range");
    chk_panel_up: assert property (display_enable [*5] |-> panel_on) else $error("panel off");
    chk_panel_down: assert property (!display_enable [*5] |-> !panel_on) else $error("panel on");
    chk_latch_ans: assert property (s_fall |-> ##[3:7] (line_strobe || !line_ready)) else $error("no line");
    chk_frame_row: assert property (s_fall ##0 frame_start |-> ##[3:7] s_row0) else $error("frame row");
    chk_strobe_src: assert property (line_strobe |-> $past(line_ready)) else $error("stray strobe");
endmodule : elp_line_scan_props

// ===== verification/elp_host_model.sv
// host controller model streaming rows into the panel input
`timescale 1ns/100ps
module elp_host_model (
    input  wire logic  core_clk,
    output logic       shift_clk,
    output logic [3:0] data,
    output logic       latch,
    output logic       fstart
);
    initial begin
        shift_clk = 1'b1;
        data      = 4'h0;
        latch     = 1'b0;
        fstart    = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge core_clk);
    endtask : hold
    task automatic send_row(input logic [639:0] dots, input logic fs);
        for (int i = 0; i < 160; i++) begin
            data = dots[639-4*i -: 4];
            hold(4);
            shift_clk = 1'b0;
            hold(4);
            shift_clk = 1'b1;
        end
        data   = ~data; // stale bus never looks valid
        latch  = 1'b1;
        fstart = fs;
        hold(4);
        latch  = 1'b0;
        hold(4);
        fstart = 1'b0;
        // frames here run far faster than the 60 hz floor; real hosts pace them
        hold(2800); // keeps latches 40 us apart
    endtask : send_row
endmodule : elp_host_model

// ===== verification/elp_line_scan_tb_top.sv
// self-checking bench for the panel line scan input
`timescale 1ns/100ps
module elp_line_scan_tb_top;
    logic         core_clk, resetn, sclk, latch, fs, en, lsel, rdy, pair, pon, strb, ovr;
    logic [3:0]   dbus;
    logic [639:0] cols;
    logic [6:0]   row;
    int           miscompares = 0, total_checks = 0, n_strb = 0, n_ovr = 0, cycles = 0;
    localparam logic [639:0] PAT = {10{64'h0f1e_2d3c_4b5a_6978}};
    elp_host_model u_elp_host_model (.core_clk(core_clk), .shift_clk(sclk), .data(dbus), .latch(latch), .fstart(fs));
    elp_line_scan u_elp_line_scan (.core_clk(core_clk), .resetn(resetn), .pixel_shift_clock(sclk),
        .pixel_data_bus(dbus), .line_latch_pulse(latch), .frame_start(fs), .display_enable(en),
        .line_select(lsel), .col_drive(cols), .row_drive(row), .row_pair(pair), .panel_on(pon),
        .line_strobe(strb), .line_ready(rdy), .overrun(ovr));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        n_strb <= n_strb + int'(strb === 1'b1);
        n_ovr  <= n_ovr + int'(ovr === 1'b1);
        if (cycles == 40000) begin
            $display("ERROR t=%0t timeout", $time);
            miscompares++;
            test_done();
        end
    end
    task automatic chk(input logic [639:0] got, input logic [639:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic t_normal();
        u_elp_host_model.send_row(PAT, 1'b1);
        chk(640'(n_strb), 640'h1);
        chk(cols, PAT);
        chk(640'(row), 640'h0);
        chk(640'(pair), 640'h0);
        u_elp_host_model.send_row(~PAT, 1'b0);
        chk(cols, ~PAT);
        chk(640'(row), 640'h1);
    endtask : t_normal
    task automatic t_dual();
        en = 1'b0;
        u_elp_host_model.hold(8);
        chk(640'(pon), 640'h0);
        lsel = 1'b1;
        u_elp_host_model.hold(4);
        en = 1'b1;
        u_elp_host_model.hold(8);
        chk(640'(pon), 640'h1);
        u_elp_host_model.send_row(~PAT, 1'b1);
        chk(640'(pair), 640'h1);
        chk(640'(row), 640'h0);
    endtask : t_dual
    task automatic t_stall();
        int s;
        s = n_strb;
        rdy = 1'b0; // receiver stalls, third line must drop
        u_elp_host_model.send_row(PAT, 1'b0);
        u_elp_host_model.send_row(PAT >> 4, 1'b0);
        u_elp_host_model.send_row(~PAT, 1'b0);
        chk(640'(n_ovr), 640'h1);
        rdy = 1'b1;
        u_elp_host_model.hold(20);
        chk(640'(n_strb - s), 640'h2);
        chk(cols, PAT >> 4);
    endtask : t_stall
    task automatic t_reset();
        resetn = 1'b0; // select stays high across the reset
        u_elp_host_model.hold(4);
        chk(640'(pon), 640'h0);
        chk(640'(pair), 640'h0);
        resetn = 1'b1;
        u_elp_host_model.hold(8);
        chk(640'(pon), 640'h1);
        u_elp_host_model.send_row(PAT, 1'b0);
        chk(640'(row), 640'h0);
        chk(640'(pair), 640'h1);
        chk(cols, PAT);
    endtask : t_reset
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        core_clk = 1'b0;
        resetn   = 1'b0;
        en       = 1'b1;
        lsel     = 1'b0;
        rdy      = 1'b1;
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        t_normal();
        t_dual();
        t_stall();
        t_reset();
        test_done();
    end
endmodule : elp_line_scan_tb_top
bind elp_line_scan elp_line_scan_props u_elp_line_scan_props (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .line_latch_pulse (line_latch_pulse),
    .frame_start      (frame_start),
    .display_enable   (display_enable),
    .col_drive        (col_drive),
    .row_drive        (row_drive),
    .row_pair         (row_pair),
    .panel_on         (panel_on),
    .line_strobe      (line_strobe),
    .line_ready       (line_ready)
);
